/* rtl/asci_top.sv */
// Purpose: Conversion timing and serial readout of a 16-bit converter
// Assumes: Host pins asynchronous; adc_sample comes from ref_clk logic
// Notes: Serial clock is sampled, so its period must span several cycles
`timescale 1ns/1ps
module asci_top
    import asci_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic convert_strobe,
    input wire logic serial_in,
    input wire logic serial_clk,
    input wire logic supply_low,
    input wire logic [RESULT_W-1:0] adc_sample,
    output logic serial_out,
    output logic serial_out_oe_n
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [SYNC_W-1:0] pin_w; // Raw host pins
    logic [SYNC_W-1:0] lvl_w; // Synchronised levels
    logic [SYNC_W-1:0] rise_w; // Rising edges
    logic [SYNC_W-1:0] fall_w; // Falling edges

    assign pin_w = {supply_low, serial_clk, serial_in, convert_strobe};

    asci_sync u_sync (
        .clk(ref_clk),
        .rst(rst),
        .din(pin_w),
        .level(lvl_w),
        .rise(rise_w),
        .fall(fall_w)
    );

    logic cnv_s; // Strobe level
    logic sdi_s; // Serial input level
    logic sck_s; // Serial clock level
    logic low_s; // Low supply range selected
    logic start_w; // Accepted strobe rise
    logic sck_fall_w; // Falling serial clock

    assign cnv_s = lvl_w[SY_CNV];
    assign sdi_s = lvl_w[SY_SDI];
    assign sck_s = lvl_w[SY_SCK];
    assign low_s = lvl_w[SY_LOW];
    assign sck_fall_w = fall_w[SY_SCK];

    ////////////////////////////////////////////////////////////////////
    // State
    asci_state_t state_r, state_nxt; // Conversion phase
    logic [CNT_W-1:0] cnt_r, cnt_nxt; // Conversion cycle count
    logic [CNT_W-1:0] len_r, len_nxt; // Length for this conversion
    logic mode_cs_r, mode_cs_nxt; // High: select mode, low: chain
    logic busy_en_r, busy_en_nxt; // Busy indication armed
    logic lead_r, lead_nxt; // Busy lead bit still on the line
    logic [RESULT_W-1:0] shift_r, shift_nxt; // Outgoing word
    logic [IDX_W-1:0] idx_r, idx_nxt; // Bits already shifted
    logic empty_r, empty_nxt; // Select mode: all bits gone
    logic out_nxt; // Next serial_out
    logic oe_n_nxt; // Next serial_out_oe_n

    logic done_w; // Last conversion cycle
    logic en_w; // Select mode enable: either line low
    logic shift_w; // A bit advances this cycle

    // A strobe rise during conversion is dropped: host keeps spacing
    assign start_w = rise_w[SY_CNV] && (state_r != ST_CONV);
    assign done_w = (state_r == ST_CONV) && (cnt_r == len_r - CNT_ONE);
    assign en_w = !cnv_s || !sdi_s;
    assign shift_w = sck_fall_w && (state_r == ST_READY) && !lead_r &&
                     (mode_cs_r ? (en_w && !empty_r) : 1'b1);

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        len_nxt = len_r;
        mode_cs_nxt = mode_cs_r;
        busy_en_nxt = busy_en_r;
        case (state_r)
            ST_IDLE, ST_READY: begin
                if (start_w) begin
                    state_nxt = ST_CONV;
                    cnt_nxt = CNT_ZERO;
                    // Range picks the internal conversion length
                    len_nxt = low_s ? CONV_LO_LEN : CONV_HI_LEN;
                    mode_cs_nxt = sdi_s;
                    // Chain mode arms busy from the clock level
                    busy_en_nxt = !sdi_s && sck_s;
                end
            end
            ST_CONV: begin
                cnt_nxt = cnt_r + CNT_ONE;
                if (done_w) begin
                    state_nxt = ST_READY;
                    if (mode_cs_r) begin
                        busy_en_nxt = en_w;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Readout shifter
    always_comb begin
        shift_nxt = shift_r;
        idx_nxt = idx_r;
        empty_nxt = empty_r;
        lead_nxt = lead_r;
        if (done_w) begin
            shift_nxt = adc_sample;
            idx_nxt = IDX_ZERO;
            empty_nxt = 1'b0;
            lead_nxt = busy_en_nxt;
        end else if (start_w) begin
            empty_nxt = 1'b0;
            lead_nxt = 1'b0;
        end else if (state_r == ST_READY && sck_fall_w && lead_r &&
                     (!mode_cs_r || en_w)) begin
            // First falling clock retires the busy lead bit
            lead_nxt = 1'b0;
        end else if (shift_w) begin
            // Chain feeds upstream data in behind the word
            shift_nxt = {shift_r[RES_MSB-1:0],
                         mode_cs_r ? 1'b0 : sdi_s};
            idx_nxt = idx_r + IDX_ONE;
            if (mode_cs_r && idx_r == IDX_LAST) begin
                empty_nxt = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output pin selection
    always_comb begin
        out_nxt = 1'b0;
        oe_n_nxt = 1'b1;
        if (mode_cs_r) begin
            if (!en_w || state_r == ST_IDLE) begin
                oe_n_nxt = 1'b1;
            end else if (state_r == ST_CONV) begin
                // Busy level while converting with the line enabled
                oe_n_nxt = 1'b0;
                out_nxt = 1'b1;
            end else if (!empty_r) begin
                oe_n_nxt = 1'b0;
                out_nxt = lead_r ? 1'b0 : shift_r[RES_MSB];
            end
        end else begin
            // Chain mode drives the line at all times
            oe_n_nxt = 1'b0;
            if (state_r == ST_READY) begin
                out_nxt = lead_r ? sdi_s : shift_r[RES_MSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            len_r <= CONV_HI_LEN;
            mode_cs_r <= MODE_CS_RST;
            busy_en_r <= 1'b0;
            lead_r <= 1'b0;
            shift_r <= '0;
            idx_r <= IDX_ZERO;
            empty_r <= 1'b1;
            serial_out <= 1'b0;
            serial_out_oe_n <= OE_N_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            len_r <= len_nxt;
            mode_cs_r <= mode_cs_nxt;
            busy_en_r <= busy_en_nxt;
            lead_r <= lead_nxt;
            shift_r <= shift_nxt;
            idx_r <= idx_nxt;
            empty_r <= empty_nxt;
            serial_out <= out_nxt;
            serial_out_oe_n <= oe_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    localparam int A_HI_MIN = CONV_HI_MIN_CYC;
    localparam int A_HI_MAX = CONV_HI_MAX_CYC;
    localparam int A_LO_MIN = CONV_LO_MIN_CYC;
    localparam int A_LO_MAX = CONV_LO_MAX_CYC;

    AST_CONV_HI: assert property (
        @(posedge ref_clk) disable iff (rst)
        start_w && !low_s |-> ##[A_HI_MIN:A_HI_MAX] done_w)
        else $error("High range conversion outside its window");

    AST_CONV_LO: assert property (
        @(posedge ref_clk) disable iff (rst)
        start_w && low_s |-> ##[A_LO_MIN:A_LO_MAX] done_w)
        else $error("Low range conversion outside its window");

    AST_MODE_PICK: assert property (
        @(posedge ref_clk) disable iff (rst)
        start_w |=> mode_cs_r == $past(sdi_s))
        else $error("Mode not taken from serial input at strobe rise");

    AST_CHAIN_BUSY_EN: assert property (
        @(posedge ref_clk) disable iff (rst)
        start_w && !sdi_s |=> busy_en_r == $past(sck_s))
        else $error("Chain busy enable not taken from clock level");

    AST_CS_BUSY_EN: assert property (
        @(posedge ref_clk) disable iff (rst)
        done_w && mode_cs_r
        |=> busy_en_r == $past(en_w) && lead_r == $past(en_w))
        else $error("Select mode busy enable wrong at completion");

    AST_RESULT_LOAD: assert property (
        @(posedge ref_clk) disable iff (rst)
        done_w |=> shift_r == $past(adc_sample) && state_r == ST_READY)
        else $error("Result not loaded at completion");

    AST_TOP_BIT: assert property (
        @(posedge ref_clk) disable iff (rst)
        mode_cs_r && state_r == ST_READY && en_w && !empty_r && !lead_r
        |=> !serial_out_oe_n && serial_out == $past(shift_r[RES_MSB]))
        else $error("Select mode output not showing current bit");

    AST_RELEASE: assert property (
        @(posedge ref_clk) disable iff (rst)
        mode_cs_r && (!en_w || empty_r) && state_r != ST_CONV
        |=> serial_out_oe_n)
        else $error("Select mode output not released");

    AST_ADVANCE: assert property (
        @(posedge ref_clk) disable iff (rst)
        shift_w && !done_w && !start_w
        |=> idx_r == $past(idx_r) + IDX_ONE &&
            shift_r[RES_MSB] == $past(shift_r[RES_MSB-1]))
        else $error("Output did not advance on falling clock");

    AST_CHAIN_CAPTURE: assert property (
        @(posedge ref_clk) disable iff (rst)
        shift_w && !mode_cs_r && !done_w && !start_w
        |=> shift_r[0] == $past(sdi_s))
        else $error("Chain mode did not capture serial input");

    AST_CHAIN_BUSY_OUT: assert property (
        @(posedge ref_clk) disable iff (rst)
        !mode_cs_r && state_r == ST_READY && lead_r && sdi_s
        |=> serial_out && !serial_out_oe_n)
        else $error("Chain busy did not follow serial input high");
endmodule // asci_top

/* rtl/asci_pkg.sv */
// Purpose: Shared constants for the converter conversion and readout logic
// Assumes: ref_clk at 50 MHz, all host pins sampled through synchronisers
// Notes: Conversion lengths sit inside the documented windows
//
// Behaviour
// - High supply: result ready 0.5 to 2.2 us
// - Low supply: result ready 0.7 to 3.2 us
// - Enable low drives top result bit first
// - Release output on enable high or last bit
// - Advance output bit after each falling clock
// - Sample serial input at strobe rise
// - Chain mode captures serial input on falling clock
// - Chain busy: output follows serial input high
// - Chain mode samples serial clock at strobe rise
// - Serial input low selects chain, high selects select-mode
// - Clock high at strobe rise enables chain busy
// - Chain output repeats input sixteen clocks later
// - Select-mode busy if enable low at completion
package asci_pkg;
    // Clock rate and documented conversion windows
    localparam int CLK_MHZ = 50;
    localparam int CONV_HI_MIN_NS = 500;
    localparam int CONV_HI_MAX_NS = 2200;
    localparam int CONV_LO_MIN_NS = 700;
    localparam int CONV_LO_MAX_NS = 3200;
    // Chosen internal conversion lengths, well inside each window
    localparam int CONV_HI_NS = 1000;
    localparam int CONV_LO_NS = 1500;

    // Least times round up, longest times round down
    localparam int CONV_HI_MIN_CYC = (CONV_HI_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_HI_MAX_CYC = (CONV_HI_MAX_NS * CLK_MHZ) / 1000;
    localparam int CONV_LO_MIN_CYC = (CONV_LO_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_LO_MAX_CYC = (CONV_LO_MAX_NS * CLK_MHZ) / 1000;

    // Conversion counter
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CONV_HI_LEN =
        CNT_W'((CONV_HI_NS * CLK_MHZ) / 1000);
    localparam logic [CNT_W-1:0] CONV_LO_LEN =
        CNT_W'((CONV_LO_NS * CLK_MHZ) / 1000);
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // Result word
    localparam int RESULT_W = 16;
    localparam int RES_MSB = RESULT_W - 1;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(RESULT_W - 1);
    localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
    localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;

    // Synchroniser lanes
    localparam int SYNC_W = 4;
    localparam int SY_CNV = 0;
    localparam int SY_SDI = 1;
    localparam int SY_SCK = 2;
    localparam int SY_LOW = 3;

    // Reset values
    localparam logic MODE_CS_RST = 1'b1;
    localparam logic OE_N_RST = 1'b1;

    // Conversion state
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CONV  = 2'b01,
        ST_READY = 2'b10
    } asci_state_t;
endpackage

/* rtl/asci_sync.sv */
// Purpose: Two-flop synchroniser with edge detection for host pins
// Assumes: Inputs are asynchronous to clk
// Notes: Edges are taken from the second and third flops only
`timescale 1ns/1ps
module asci_sync
    import asci_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [SYNC_W-1:0] din,
    output logic [SYNC_W-1:0] level,
    output logic [SYNC_W-1:0] rise,
    output logic [SYNC_W-1:0] fall
);
    logic [SYNC_W-1:0] meta_r; // First stage, read only by stage two
    logic [SYNC_W-1:0] sync_r; // Settled level
    logic [SYNC_W-1:0] past_r; // Previous settled level

    ////////////////////////////////////////////////////////////////////
    // Shift chain
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
            past_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            past_r <= sync_r;
        end
    end

    // Edge decode
    assign level = sync_r;
    assign rise = sync_r & ~past_r;
    assign fall = ~sync_r & past_r;
endmodule // asci_sync

/* bench/asci_host_model.sv */
// Purpose: Host controller model driving strobe, serial input and clock
// Assumes: Serial clock from ref_clk, 160 ns period, idle between frames
// Notes: Released output line is seen as the inverse of its last level
`timescale 1ns/1ps
module asci_host_model
    import asci_pkg::*;
(
    input wire logic ref_clk,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    output logic convert_strobe,
    output logic serial_in,
    output logic serial_clk,
    output logic [RESULT_W-1:0] got,
    output logic got_valid
);
    realtime rise_time = -1.0e6; // Time of the last strobe rise
    logic last_lvl = 1'b0; // Last level driven on the line
    logic line_lvl; // Wire level as the host sees it
    initial begin
        convert_strobe = 1'b0;
        serial_in = 1'b1;
        serial_clk = 1'b0;
        got = 16'h0000;
        got_valid = 1'b0;
    end
    // Undriven line must not look like a held bit
    assign line_lvl = serial_out_oe_n ? ~last_lvl : serial_out;
    always @(posedge ref_clk) begin
        if (!serial_out_oe_n) last_lvl <= serial_out;
    end
    ////////////////////////////////////////////////////////////////////////
    // Launch a conversion with mode levels held around the strobe rise
    task automatic convert(input logic mode_in, input logic clk_lvl,
                           input logic drop);
        convert_strobe <= 1'b0;
        serial_in <= mode_in;
        serial_clk <= clk_lvl;
        repeat (4) @(posedge ref_clk);
        while ($realtime - rise_time < 5000.0) @(posedge ref_clk);
        convert_strobe <= 1'b1;
        rise_time = $realtime;
        repeat (2) @(posedge ref_clk);
        serial_clk <= 1'b0;
        if (drop) convert_strobe <= 1'b0;
    endtask
    // Longest conversion plus pin latency before any shifting
    task automatic wait_done();
        repeat (CONV_LO_MAX_CYC + 8) @(posedge ref_clk);
    endtask
    // Change serial input and let it cross the synchronisers
    task automatic set_in(input logic v);
        serial_in <= v;
        repeat (8) @(posedge ref_clk);
    endtask
    // One clock: sample before the falling edge that advances
    task automatic bit_cycle(input logic din, output logic dout);
        serial_in <= din;
        serial_clk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        dout = line_lvl;
        serial_clk <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    // Sixteen clocks, MSB first, upstream word fed on serial input
    task automatic rd_word(input logic [RESULT_W-1:0] up);
        logic b;
        logic [RESULT_W-1:0] w;
        set_in(up[RES_MSB]);
        for (int i = RES_MSB; i >= 0; i--) begin
            bit_cycle(up[i], b);
            w[i] = b;
        end
        got <= w;
        got_valid <= 1'b1;
        @(posedge ref_clk);
        got_valid <= 1'b0;
    endtask
endmodule // asci_host_model

/* bench/adc_serial_conversion_interface_tb_top.sv */
// Purpose: Self-checking bench for conversion timing and serial readout
// Assumes: Host model drives strobe, serial input and clock; bench drives range and sample
// Notes: Expected words queue up and are compared as frames complete
`timescale 1ns/1ps
module adc_serial_conversion_interface_tb_top;
    import asci_pkg::*;
    logic ref_clk = 1'b0; // System clock
    logic rst = 1'b1; // Synchronous reset
    logic supply_low = 1'b0; // Range select
    logic [RESULT_W-1:0] adc_sample = 16'h0000; // Converted sample
    logic convert_strobe;
    logic serial_in;
    logic serial_clk;
    logic serial_out;
    logic serial_out_oe_n;
    logic [RESULT_W-1:0] got; // Word captured by the host
    logic got_valid;
    logic [RESULT_W-1:0] exp_q[$]; // Expected words, oldest first
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 27;
    asci_top u_dut (.ref_clk(ref_clk), .rst(rst),
        .convert_strobe(convert_strobe), .serial_in(serial_in),
        .serial_clk(serial_clk), .supply_low(supply_low),
        .adc_sample(adc_sample), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n));
    asci_host_model u_host (.ref_clk(ref_clk), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .convert_strobe(convert_strobe),
        .serial_in(serial_in), .serial_clk(serial_clk), .got(got),
        .got_valid(got_valid));
    // 20 ns clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] expv);
        tests_run++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Compare each finished frame with the oldest note
    always @(posedge ref_clk) begin
        if (got_valid === 1'b1) begin
            if (exp_q.size() == 0) check("word_extra", got, ~got);
            else check("word", got, exp_q.pop_front());
        end
    end
    // Hang guard, several times the expected run
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic ok;
        logic b;
        logic [RESULT_W-1:0] up;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // Look mid-cycle, while the registers still hold the values loaded by reset
        @(negedge ref_clk);
        check("rst_oe_n", 16'(serial_out_oe_n), 16'h0001);
        check("rst_out", 16'(serial_out), 16'h0000);
        @(posedge ref_clk);
        // Select mode, strobe low through conversion: busy then lead bit
        for (int s = 0; s < 2; s++) begin
            supply_low <= s[0];
            adc_sample <= 16'($random(seed));
            u_host.convert(1'b1, 1'b0, 1'b1);
            n = 2;
            while (!(serial_out_oe_n === 1'b0 && serial_out === 1'b1)
                   && n < 300) begin
                @(posedge ref_clk);
                n++;
            end
            check("busy_high", 16'(serial_out), 16'h0001);
            while (serial_out !== 1'b0 && n < 300) begin
                @(posedge ref_clk);
                n++;
            end
            ok = s ? (n >= CONV_LO_MIN_CYC && n <= CONV_LO_MAX_CYC)
                   : (n >= CONV_HI_MIN_CYC && n <= CONV_HI_MAX_CYC);
            check("conv_time", 16'(ok), 16'h0001);
            u_host.bit_cycle(1'b1, b);
            check("lead_bit", 16'(b), 16'h0000);
            exp_q.push_back(adc_sample);
            u_host.rd_word(16'hFFFF);
            check("release_last", 16'(serial_out_oe_n), 16'h0001);
        end
        // Select mode, strobe held high, serial input enables
        adc_sample <= 16'($random(seed));
        u_host.convert(1'b1, 1'b0, 1'b0);
        u_host.wait_done();
        check("off_enable_high", 16'(serial_out_oe_n), 16'h0001);
        exp_q.push_back(adc_sample);
        u_host.rd_word(16'h0000);
        check("release_end", 16'(serial_out_oe_n), 16'h0001);
        // Chain mode without busy: word then upstream bits
        adc_sample <= 16'($random(seed));
        up = 16'($random(seed));
        u_host.convert(1'b0, 1'b0, 1'b0);
        u_host.wait_done();
        check("chain_drive", 16'(serial_out_oe_n), 16'h0000);
        exp_q.push_back(adc_sample);
        exp_q.push_back(up);
        u_host.rd_word(up);
        u_host.rd_word(16'h0000);
        // Chain mode with busy: output follows serial input
        adc_sample <= 16'($random(seed));
        u_host.convert(1'b0, 1'b1, 1'b0);
        u_host.wait_done();
        check("chain_low", 16'(u_host.line_lvl), 16'h0000);
        u_host.set_in(1'b1);
        check("chain_busy", 16'(u_host.line_lvl), 16'h0001);
        u_host.bit_cycle(1'b1, b);
        check("chain_lead", 16'(b), 16'h0001);
        exp_q.push_back(adc_sample);
        u_host.rd_word(16'h0000);
        repeat (4) @(posedge ref_clk);
        check("queue_left", 16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule // adc_serial_conversion_interface_tb_top
